// ---- rtl/e1_ctrl_defs.vh ----
`ifndef E1_CTRL_DEFS_VH
`define E1_CTRL_DEFS_VH

// Register addresses on the parallel port
`define ADDR_STATUS_1      8'h06
`define ADDR_STATUS_2      8'h07
`define ADDR_RX_INFO       8'h08
`define ADDR_IRQ_MASK_1    8'h16
`define ADDR_IRQ_MASK_2    8'h17
`define ADDR_COMMON_CTRL_1 8'h14
`define ADDR_COMMON_CTRL_2 8'h1A
`define ADDR_COMMON_CTRL_3 8'h1B
`define ADDR_SYNC_STATE    8'h1E

// Field positions
`define CC1_FRAMER_LB   7
`define CC2_LOCAL_LB    0
`define CC2_REMOTE_LB   1
`define CC2_AUTO_RA     4
`define CC2_AUTO_AIS    5
`define CC3_LINE_IF_RST 3
`define CC3_STORE_RST   4

// Receive information bit positions
`define RIF_SIG_MF      0
`define RIF_FRAME_ALIGN 1
`define RIF_CRC         2
`define RIF_RX_EMPTY    3
`define RIF_RX_FULL     4
`define RIF_JITTER      5
`define RIF_TX_EMPTY    6
`define RIF_TX_FULL     7

`define REG_RESET 8'h00

// Resync criteria end points
`define CRC_LAST_BLOCK  10'h3E7
`define CRC_TRIP_ERRS   10'h392
`define FAS_RUN_LAST    2'h2

// Line interface recovery time
`define LIF_RECOVER_MS  40
`define CLK_MHZ         250
`define LIF_RECOVER_CYC (`LIF_RECOVER_MS * 1000 * `CLK_MHZ)

`endif

// ---- rtl/latched_status.v ----
`timescale 1ns/1ps
// One latched status byte with mask-write refresh and interrupt gating
module latched_status (
  input  wire       mclk_i,
  input  wire       rst_i,
  input  wire [7:0] event_i,
  input  wire       wr_i,
  input  wire [7:0] wdata_i,
  input  wire [7:0] mask_i,
  output reg  [7:0] read_copy_o,
  output reg        irq_o
);
  reg  [7:0] latch;
  wire [7:0] next_latch;

  // Event in a clearing cycle wins over the clear
  assign next_latch = wr_i ? ((latch & ~wdata_i) | event_i)
                           : (latch | event_i);

  always @(posedge mclk_i) begin
    if (rst_i) begin
      latch       <= 8'h00;
      read_copy_o <= 8'h00;
      irq_o       <= 1'b0;
    end else begin
      latch <= next_latch;
      if (wr_i)
        read_copy_o <= (read_copy_o & ~wdata_i)
                     | ((latch | event_i) & wdata_i);
      irq_o <= |(next_latch & mask_i);
    end
  end
endmodule // latched_status

// ---- rtl/e1_loopback_alarm_status_ctrl.v ----
`timescale 1ns/1ps
// Operation
// - Local loopback: transmit normally, receive path takes transmit data.
// - Remote loopback: resend recovered line data, ignore serial input.
// - Framer loopback: transmit into receive, drive line, ignore line in.
// - Framer loopback: receive clock follows the transmit clock input.
// - On sync, AIS or carrier loss send AIS or remote alarm.
// - Line-interface reset rising; about 40 ms until operational.
// - Status bits latch on events until read and cleared.
// - Mask write: ones refresh readable copy and clear; zeros hold.
// - Synchronizer state register is read-only and real time.
// - Status 1 drives interrupt 1, status 2 interrupt 2, maskable.
// - Elastic-store full and empty flags set on delete or repeat.
// - Jitter limit flag set within 4 bits of FIFO limit.
// - CRC resync flag set at 915 of 1000 errored codewords.
// - Frame-align resync flag on three consecutive errored words.
// - Signaling multiframe flag on two consecutive errored words.
// - Elastic-store reset falling edge forces known store depth.
// - Line-interface reset rising edge resets the line front end.
`include "e1_ctrl_defs.vh"
module e1_loopback_alarm_status_ctrl #(
  parameter LIF_RECOVER_CYCLES = `LIF_RECOVER_CYC
) (
  input  wire       mclk_i,
  input  wire       rst_i,
  // Parallel port
  input  wire       wr_i,
  input  wire       rd_i,
  input  wire [7:0] addr_i,
  input  wire [7:0] wdata_i,
  output reg  [7:0] rdata_o,
  // Line and datapath, sampled
  input  wire       line_rx_pos_i,
  input  wire       line_rx_neg_i,
  input  wire       tx_pos_i,
  input  wire       tx_neg_i,
  input  wire       tx_serial_in_i,
  input  wire       tx_clock_in_i,
  input  wire       rec_clock_i,
  output reg        line_tx_pos_o,
  output reg        line_tx_neg_o,
  output reg        rx_pos_o,
  output reg        rx_neg_o,
  output reg        rx_clock_o,
  output reg        tx_serial_used_o,
  output reg        jitter_path_o,
  // Receive-side conditions and events
  input  wire       loss_of_sync_i,
  input  wire       rx_all_ones_i,
  input  wire       loss_of_carrier_i,
  input  wire [7:0] status_1_event_i,
  input  wire [7:0] status_2_event_i,
  input  wire       rx_store_slip_full_i,
  input  wire       rx_store_slip_empty_i,
  input  wire       tx_store_slip_full_i,
  input  wire       tx_store_slip_empty_i,
  input  wire       jitter_near_limit_i,
  input  wire       crc_block_i,
  input  wire       crc_error_i,
  input  wire       fas_word_i,
  input  wire       fas_error_i,
  input  wire       casmf_word_i,
  input  wire       casmf_error_i,
  input  wire [7:0] sync_state_i,
  // Controls
  output reg        force_ais_o,
  output reg        force_remote_alarm_o,
  output reg        line_if_reset_o,
  output reg        line_if_ready_o,
  output reg        store_recenter_o,
  output reg        irq_out_1_o,
  output reg        irq_out_2_o
);
  reg  [7:0]  common_ctrl_1;
  reg  [7:0]  common_ctrl_2;
  reg  [7:0]  common_ctrl_3;
  reg  [7:0]  irq_mask_1;
  reg  [7:0]  irq_mask_2;
  reg  [7:0]  sync_meta;
  reg  [7:0]  sync_state_reg;
  reg  [4:0]  pin_meta;
  reg  [4:0]  pin_sync;
  reg  [1:0]  fas_run;
  reg         cas_run;
  reg  [9:0]  crc_blocks;
  reg  [9:0]  crc_errs;
  reg  [31:0] lif_count;
  reg         alarm_cond;
  wire [7:0]  status_reg_1;
  wire [7:0]  status_reg_2;
  wire [7:0]  receive_information_flags;
  wire        irq_1;
  wire        irq_2;
  wire        wr_s1;
  wire        wr_s2;
  wire        wr_ri;
  wire        crc_trip;
  wire [7:0]  rx_info_events;

  function hit;
    input [7:0] a;
    input [7:0] b;
    hit = (a == b);
  endfunction

  assign wr_s1 = wr_i && hit(addr_i, `ADDR_STATUS_1);
  assign wr_s2 = wr_i && hit(addr_i, `ADDR_STATUS_2);
  assign wr_ri = wr_i && hit(addr_i, `ADDR_RX_INFO);

  // Window closes at 1000 blocks; trip on the 915th error inside it
  assign crc_trip = crc_block_i && crc_error_i
                 && (crc_errs == `CRC_TRIP_ERRS);

  assign rx_info_events = {tx_store_slip_full_i, tx_store_slip_empty_i,
                           jitter_near_limit_i,
                           rx_store_slip_full_i,
                           rx_store_slip_empty_i,
                           crc_trip,
                           fas_word_i && fas_error_i
                           && fas_run == `FAS_RUN_LAST,
                           casmf_word_i && casmf_error_i && cas_run};

  latched_status u_s1 (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .event_i     (status_1_event_i),
    .wr_i        (wr_s1),
    .wdata_i     (wdata_i),
    .mask_i      (irq_mask_1),
    .read_copy_o (status_reg_1),
    .irq_o       (irq_1)
  );

  latched_status u_s2 (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .event_i     (status_2_event_i),
    .wr_i        (wr_s2),
    .wdata_i     (wdata_i),
    .mask_i      (irq_mask_2),
    .read_copy_o (status_reg_2),
    .irq_o       (irq_2)
  );

  // Receive information flags raise no interrupt
  latched_status u_ri (
    .mclk_i      (mclk_i),
    .rst_i       (rst_i),
    .event_i     (rx_info_events),
    .wr_i        (wr_ri),
    .wdata_i     (wdata_i),
    .mask_i      (8'h00),
    .read_copy_o (receive_information_flags),
    .irq_o       ()
  );

  // Control registers and read port
  always @(posedge mclk_i) begin
    if (rst_i) begin
      common_ctrl_1 <= `REG_RESET;
      common_ctrl_2 <= `REG_RESET;
      common_ctrl_3 <= `REG_RESET;
      irq_mask_1    <= `REG_RESET;
      irq_mask_2    <= `REG_RESET;
      rdata_o       <= 8'h00;
    end else begin
      if (wr_i) begin
        if (hit(addr_i, `ADDR_COMMON_CTRL_1)) common_ctrl_1 <= wdata_i;
        if (hit(addr_i, `ADDR_COMMON_CTRL_2)) common_ctrl_2 <= wdata_i;
        if (hit(addr_i, `ADDR_COMMON_CTRL_3)) common_ctrl_3 <= wdata_i;
        if (hit(addr_i, `ADDR_IRQ_MASK_1))    irq_mask_1    <= wdata_i;
        if (hit(addr_i, `ADDR_IRQ_MASK_2))    irq_mask_2    <= wdata_i;
      end
      if (rd_i) begin
        case (addr_i)
          `ADDR_STATUS_1:      rdata_o <= status_reg_1;
          `ADDR_STATUS_2:      rdata_o <= status_reg_2;
          `ADDR_RX_INFO:       rdata_o <= receive_information_flags;
          `ADDR_COMMON_CTRL_1: rdata_o <= common_ctrl_1;
          `ADDR_COMMON_CTRL_2: rdata_o <= common_ctrl_2;
          `ADDR_COMMON_CTRL_3: rdata_o <= common_ctrl_3;
          `ADDR_IRQ_MASK_1:    rdata_o <= irq_mask_1;
          `ADDR_IRQ_MASK_2:    rdata_o <= irq_mask_2;
          `ADDR_SYNC_STATE:    rdata_o <= sync_state_reg;
          default:             rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // Resync criteria counters
  always @(posedge mclk_i) begin
    if (rst_i) begin
      fas_run    <= 2'd0;
      cas_run    <= 1'b0;
      crc_blocks <= 10'd0;
      crc_errs   <= 10'd0;
    end else begin
      if (fas_word_i)
        fas_run <= fas_error_i ? ((fas_run == `FAS_RUN_LAST) ? 2'd0
                                  : fas_run + 2'd1) : 2'd0;
      if (casmf_word_i)
        cas_run <= casmf_error_i && !cas_run;
      if (crc_block_i) begin
        if (crc_blocks == `CRC_LAST_BLOCK) begin
          crc_blocks <= 10'd0;
          crc_errs   <= 10'd0;
        end else begin
          crc_blocks <= crc_blocks + 10'd1;
          if (crc_error_i) crc_errs <= crc_errs + 10'd1;
        end
      end
    end
  end

  // Line pins and clocks cross in through two flops
  always @(posedge mclk_i) begin
    if (rst_i) begin
      pin_meta       <= 5'h00;
      pin_sync       <= 5'h00;
      sync_meta      <= 8'h00;
      sync_state_reg <= 8'h00;
    end else begin
      pin_meta       <= {rec_clock_i, tx_clock_in_i, tx_serial_in_i,
                         line_rx_neg_i, line_rx_pos_i};
      pin_sync       <= pin_meta;
      sync_meta      <= sync_state_i;
      sync_state_reg <= sync_meta;
    end
  end

  // Loopback steering and alarms
  always @(posedge mclk_i) begin
    if (rst_i) begin
      line_tx_pos_o        <= 1'b0;
      line_tx_neg_o        <= 1'b0;
      rx_pos_o             <= 1'b0;
      rx_neg_o             <= 1'b0;
      rx_clock_o           <= 1'b0;
      tx_serial_used_o     <= 1'b1;
      jitter_path_o        <= 1'b0;
      alarm_cond           <= 1'b0;
      force_ais_o          <= 1'b0;
      force_remote_alarm_o <= 1'b0;
      irq_out_1_o          <= 1'b0;
      irq_out_2_o          <= 1'b0;
    end else begin
      // Remote loopback resends raw rails, so violations survive
      if (common_ctrl_2[`CC2_REMOTE_LB]) begin
        line_tx_pos_o <= pin_sync[0];
        line_tx_neg_o <= pin_sync[1];
      end else begin
        line_tx_pos_o <= tx_pos_i;
        line_tx_neg_o <= tx_neg_i;
      end
      if (common_ctrl_1[`CC1_FRAMER_LB]
          || common_ctrl_2[`CC2_LOCAL_LB]) begin
        rx_pos_o <= tx_pos_i;
        rx_neg_o <= tx_neg_i;
      end else begin
        rx_pos_o <= pin_sync[0];
        rx_neg_o <= pin_sync[1];
      end
      rx_clock_o <= common_ctrl_1[`CC1_FRAMER_LB] ? pin_sync[3]
                                                  : pin_sync[4];
      tx_serial_used_o <= !common_ctrl_2[`CC2_REMOTE_LB];
      jitter_path_o    <= common_ctrl_2[`CC2_LOCAL_LB]
                       || common_ctrl_2[`CC2_REMOTE_LB];
      alarm_cond <= loss_of_sync_i || rx_all_ones_i || loss_of_carrier_i;
      // Illegal both-set case favours AIS alone
      force_ais_o <= alarm_cond && common_ctrl_2[`CC2_AUTO_AIS];
      force_remote_alarm_o <= alarm_cond
                           && common_ctrl_2[`CC2_AUTO_RA]
                           && !common_ctrl_2[`CC2_AUTO_AIS];
      irq_out_1_o <= irq_1;
      irq_out_2_o <= irq_2;
    end
  end

  // Line-interface reset and store recentering on edges
  reg lif_prev;
  reg store_rst_prev;
  always @(posedge mclk_i) begin
    if (rst_i) begin
      lif_prev         <= 1'b0;
      store_rst_prev   <= 1'b0;
      lif_count        <= 32'd0;
      line_if_reset_o  <= 1'b0;
      line_if_ready_o  <= 1'b0;
      store_recenter_o <= 1'b0;
    end else begin
      lif_prev <= common_ctrl_3[`CC3_LINE_IF_RST];
      store_rst_prev <= common_ctrl_3[`CC3_STORE_RST];
      line_if_reset_o  <= common_ctrl_3[`CC3_LINE_IF_RST]
                       && !lif_prev;
      store_recenter_o <= store_rst_prev
                       && !common_ctrl_3[`CC3_STORE_RST];
      if (common_ctrl_3[`CC3_LINE_IF_RST] && !lif_prev) begin
        lif_count       <= LIF_RECOVER_CYCLES;
        line_if_ready_o <= 1'b0;
      end else if (lif_count != 32'd0) begin
        lif_count <= lif_count - 32'd1;
        line_if_ready_o <= (lif_count == 32'd1);
      end
    end
  end
endmodule // e1_loopback_alarm_status_ctrl

// ---- sim/e1_line_model.sv ----
`timescale 1ns/1ps
module e1_line_model (
  input  wire       mclk_i,
  input  wire [1:0] rails_i,
  output reg        rx_pos_o,
  output reg        rx_neg_o,
  output reg        tx_clk_o,
  output reg        rec_clk_o
);
  reg [3:0] div;
  initial begin
    div = 4'h0;
    {rx_pos_o, rx_neg_o, tx_clk_o, rec_clk_o} = 4'h0;
  end
  // Unequal clock rates so a swapped receive clock shows
  always @(negedge mclk_i) begin
    div <= div + 4'h1;
    tx_clk_o <= div[3];
    rec_clk_o <= div[1];
    {rx_pos_o, rx_neg_o} <= rails_i;
  end
endmodule // e1_line_model

// ---- sim/e1_ctrl_props.sv ----
`timescale 1ns/1ps
module e1_ctrl_props #(
  parameter LIF_RECOVER_CYCLES = 20
) (
  input wire mclk_i,
  input wire rst_i,
  input wire wr_i,
  input wire loss_of_sync_i,
  input wire rx_all_ones_i,
  input wire loss_of_carrier_i,
  input wire tx_serial_used_o,
  input wire jitter_path_o,
  input wire force_ais_o,
  input wire force_remote_alarm_o,
  input wire line_if_reset_o,
  input wire line_if_ready_o,
  input wire store_recenter_o,
  input wire irq_out_1_o,
  input wire irq_out_2_o
);
  integer cnt;
  reg     armed;
  // Saturates so a long run cannot wrap
  always @(posedge mclk_i) begin
    if (rst_i || line_if_reset_o) begin
      cnt <= 0;
      armed <= line_if_reset_o;
    end else if (armed && cnt < LIF_RECOVER_CYCLES + 8) begin
      cnt <= cnt + 1;
    end
  end
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (rst_i);
  sequence quiet3;
    !(loss_of_sync_i || rx_all_ones_i || loss_of_carrier_i) [*3];
  endsequence
  sequence no_wr3;
    !wr_i [*3];
  endsequence
  alarm_idle_a: assert property (
    quiet3 |-> !force_ais_o && !force_remote_alarm_o)
    else $error("alarm with no fault");
  alarm_excl_a: assert property (
    !(force_ais_o && force_remote_alarm_o))
    else $error("both alarms");
  remote_jitter_a: assert property (
    !tx_serial_used_o |-> jitter_path_o)
    else $error("no jitter path");
  lif_pulse_a: assert property (
    line_if_reset_o |=> !line_if_reset_o)
    else $error("line reset too long");
  lif_cause_a: assert property (
    line_if_reset_o |-> $past(wr_i) || $past(wr_i, 2))
    else $error("line reset with no write");
  lif_ready_a: assert property (
    armed && cnt > LIF_RECOVER_CYCLES + 3 |-> line_if_ready_o)
    else $error("line not ready");
  recenter_pulse_a: assert property (
    store_recenter_o |=> !store_recenter_o)
    else $error("recenter too long");
  irq_hold_a: assert property (
    no_wr3 |=> !$fell(irq_out_1_o) && !$fell(irq_out_2_o))
    else $error("irq dropped");
endmodule // e1_ctrl_props

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
`include "e1_ctrl_defs.vh"
module tb_top;
  reg        mclk_i, rst_i, wr_i, rd_i, tx_pos_i, tx_neg_i, tx_serial_in_i;
  reg  [7:0] addr_i, wdata_i, status_1_event_i, status_2_event_i;
  reg  [7:0] sync_state_i, v;
  reg  [5:0] wds;
  reg  [4:0] ev;
  reg  [2:0] cond;
  reg  [1:0] rails;
  wire [7:0] rdata_o;
  wire       line_rx_pos_i, line_rx_neg_i, tx_clock_in_i, rec_clock_i;
  wire       line_tx_pos_o, line_tx_neg_o, rx_pos_o, rx_neg_o, rx_clock_o;
  wire       tx_serial_used_o, jitter_path_o, force_ais_o;
  wire       force_remote_alarm_o, line_if_reset_o, line_if_ready_o;
  wire       store_recenter_o, irq_out_1_o, irq_out_2_o;
  wire [3:0] rails_out = {rx_pos_o, rx_neg_o, line_tx_pos_o, line_tx_neg_o};
  integer    err_count, compares, i, k, lr_n, rc_n;
  e1_loopback_alarm_status_ctrl #(.LIF_RECOVER_CYCLES(20)) u_dut (
    .mclk_i, .rst_i, .wr_i, .rd_i, .addr_i, .wdata_i, .rdata_o,
    .line_rx_pos_i, .line_rx_neg_i, .tx_pos_i, .tx_neg_i, .tx_serial_in_i,
    .tx_clock_in_i, .rec_clock_i, .line_tx_pos_o, .line_tx_neg_o,
    .rx_pos_o, .rx_neg_o, .rx_clock_o, .tx_serial_used_o, .jitter_path_o,
    .loss_of_carrier_i(cond[2]), .rx_all_ones_i(cond[1]),
    .loss_of_sync_i(cond[0]), .status_1_event_i, .status_2_event_i,
    .rx_store_slip_full_i(ev[4]), .rx_store_slip_empty_i(ev[3]),
    .tx_store_slip_full_i(ev[2]), .tx_store_slip_empty_i(ev[1]),
    .jitter_near_limit_i(ev[0]), .crc_block_i(wds[5]), .crc_error_i(wds[4]),
    .fas_word_i(wds[3]), .fas_error_i(wds[2]), .casmf_word_i(wds[1]),
    .casmf_error_i(wds[0]), .sync_state_i, .force_ais_o,
    .force_remote_alarm_o, .line_if_reset_o, .line_if_ready_o,
    .store_recenter_o, .irq_out_1_o, .irq_out_2_o);
  e1_line_model u_line (.mclk_i, .rails_i(rails), .rx_pos_o(line_rx_pos_i),
    .rx_neg_o(line_rx_neg_i), .tx_clk_o(tx_clock_in_i),
    .rec_clk_o(rec_clock_i));
  always @(posedge mclk_i) begin
    lr_n <= lr_n + line_if_reset_o;
    rc_n <= rc_n + store_recenter_o;
  end
  task chk(input [7:0] got, input [7:0] exp);
    begin
      compares = compares + 1;
      if (got !== exp) begin
        err_count = err_count + 1;
        $display("MISMATCH at %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wn(input integer c);
    repeat (c) @(negedge mclk_i);
  endtask
  task wr(input [7:0] a, input [7:0] d);
    begin
      wn(1);
      wr_i = 1'h1;
      addr_i = a;
      wdata_i = d;
      wn(1);
      wr_i = 1'h0;
    end
  endtask
  // Data settles after the sampling edge; taken at the next falling edge
  task rd(input [7:0] a, output [7:0] d);
    begin
      wn(1);
      rd_i = 1'h1;
      addr_i = a;
      wn(1);
      rd_i = 1'h0;
      d = rdata_o;
    end
  endtask
  task end_sim;
    begin
      if (err_count == 0 && compares > 0)
        $display("Finished cleanly");
      else
        $display("Finished with errors");
      $finish;
    end
  endtask
  initial begin
    mclk_i = 1'h0;
    forever #2 mclk_i = ~mclk_i;
  end
  initial begin
    #20000;
    err_count = err_count + 1;
    end_sim;
  end
  initial begin
    {wr_i, rd_i, tx_pos_i, tx_neg_i, tx_serial_in_i, addr_i, wdata_i} = '0;
    {status_1_event_i, status_2_event_i, sync_state_i, wds, ev} = '0;
    {cond, rails} = '0;
    {err_count, compares, lr_n, rc_n} = '0;
    rst_i = 1'h1;
    wn(16);
    rst_i = 1'h0;
    chk({tx_serial_used_o, force_ais_o, irq_out_1_o, irq_out_2_o}, 8'h08);
    wr(`ADDR_COMMON_CTRL_1, 8'h00);
    wr(`ADDR_COMMON_CTRL_2, 8'h00);
    wr(`ADDR_COMMON_CTRL_3, 8'h00);
    wr(`ADDR_IRQ_MASK_1, 8'h00);
    wr(`ADDR_IRQ_MASK_2, 8'h00);
    wr(`ADDR_COMMON_CTRL_3, 8'h08);
    wn(2);
    chk(lr_n, 1);
    chk(line_if_ready_o, 0);
    for (i = 0; i < 60 && !line_if_ready_o; i = i + 1)
      wn(1);
    chk({line_if_ready_o, i > 12}, 8'h03);
    wr(`ADDR_COMMON_CTRL_3, 8'h18);
    wr(`ADDR_COMMON_CTRL_3, 8'h08);
    wn(3);
    chk({rc_n[3:0], lr_n[3:0]}, 8'h11);
    sync_state_i = 8'h5A;
    wr(`ADDR_SYNC_STATE, 8'h00);
    rd(`ADDR_SYNC_STATE, v);
    chk(v, 8'h5A);
    sync_state_i = 8'hA5;
    wn(3);
    rd(`ADDR_SYNC_STATE, v);
    chk(v, 8'hA5);
    rd(8'h02, v);
    chk(v, 8'h00);
    tx_pos_i = 1'h1;
    rails = 2'h1;
    wr(`ADDR_COMMON_CTRL_2, 8'h01);
    wn(5);
    chk({rails_out, jitter_path_o}, 8'h15);
    wr(`ADDR_COMMON_CTRL_2, 8'h02);
    wn(5);
    chk({rails_out, jitter_path_o, tx_serial_used_o}, 8'h16);
    wr(`ADDR_COMMON_CTRL_2, 8'h00);
    wr(`ADDR_COMMON_CTRL_1, 8'h80);
    wn(5);
    chk(rails_out, 8'h0A);
    wait (tx_clock_in_i === 1'h0);
    wait (tx_clock_in_i === 1'h1);
    wn(5);
    chk(rx_clock_o, 1);
    wn(8);
    chk(rx_clock_o, 0);
    wr(`ADDR_COMMON_CTRL_1, 8'h00);
    for (i = 0; i < 6; i = i + 1) begin
      cond = 3'h1 << (i % 3);
      wr(`ADDR_COMMON_CTRL_2, i < 3 ? 8'h20 : 8'h10);
      wn(3);
      chk({force_ais_o, force_remote_alarm_o}, i < 3 ? 2 : 1);
    end
    cond = 3'h0;
    wn(4);
    chk({force_ais_o, force_remote_alarm_o}, 8'h00);
    status_1_event_i = 8'h05;
    wn(1);
    status_1_event_i = 8'h00;
    wn(3);
    chk(irq_out_1_o, 0);
    wr(`ADDR_IRQ_MASK_1, 8'h04);
    wn(2);
    chk(irq_out_1_o, 1);
    for (k = 0; k < 3; k = k + 1) begin
      wr(`ADDR_STATUS_1, k ? 8'h01 : 8'h04);
      rd(`ADDR_STATUS_1, v);
      chk(v, k == 1 ? 8'h05 : 8'h04);
    end
    chk(irq_out_1_o, 0);
    wr(`ADDR_IRQ_MASK_2, 8'h80);
    status_2_event_i = 8'h80;
    wn(1);
    status_2_event_i = 8'h00;
    wn(2);
    chk({irq_out_1_o, irq_out_2_o}, 8'h01);
    wr(`ADDR_STATUS_2, 8'h80);
    wn(2);
    chk(irq_out_2_o, 0);
    // First round stays one short of every threshold
    for (k = 0; k < 2; k = k + 1) begin
      for (i = 0; i < 3; i = i + 1) begin
        wds = 6'h30 >> (2 * i);
        wn(k ? 1 : (i == 0 ? 914 : 3 - i));
        wds = 6'h00;
        wn(1);
      end
      ev = {5{k[0]}};
      wn(1);
      ev = 5'h00;
      wr(`ADDR_RX_INFO, 8'hFF);
      rd(`ADDR_RX_INFO, v);
      chk(v, k ? 8'hFF : 8'h00);
      wr(`ADDR_RX_INFO, v & 8'hFF);
    end
    // Split events so a swapped flag position shows
    for (k = 0; k < 2; k = k + 1) begin
      ev = k ? 5'h0B : 5'h14;
      wn(1);
      ev = 5'h00;
      wr(`ADDR_RX_INFO, 8'hFF);
      rd(`ADDR_RX_INFO, v);
      chk(v, k ? 8'h68 : 8'h90);
      wr(`ADDR_RX_INFO, v & 8'hFF);
    end
    end_sim;
  end
endmodule // tb_top
bind e1_loopback_alarm_status_ctrl e1_ctrl_props #(
  .LIF_RECOVER_CYCLES(LIF_RECOVER_CYCLES)) u_props (
  .mclk_i, .rst_i, .wr_i, .loss_of_sync_i, .rx_all_ones_i, .loss_of_carrier_i,
  .tx_serial_used_o, .jitter_path_o, .force_ais_o, .force_remote_alarm_o,
  .line_if_reset_o, .line_if_ready_o, .store_recenter_o, .irq_out_1_o,
  .irq_out_2_o);
